//--- design/hbs_pkg.sv
// package: register map, field layout and timing constants of the holding brake sequencer
package hbs_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned RELEASE_MAX_MS  = 500;
	// register offsets are word indices: byte address = 4 * index
	localparam logic [15:0] IDX_ENGAGE_DLY  = 16'h2437;
	localparam logic [15:0] IDX_RELEASE_DLY = 16'h2438;
	localparam logic [15:0] IDX_SPEED_THR   = 16'h2439;
	localparam logic [15:0] IDX_DECEL_LIM   = 16'h2614;
	localparam logic [15:0] IDX_OUT_SEL     = 16'h2411;
	localparam logic [15:0] IDX_STATUS      = 16'h2500;
	localparam int unsigned ADDR_W          = 18;
	localparam logic [15:0] ENGAGE_DLY_RST  = 16'h0064;
	localparam logic [15:0] RELEASE_DLY_RST = 16'h0000;
	localparam logic [15:0] SPEED_THR_RST   = 16'h001E;
	localparam logic [15:0] DECEL_LIM_RST   = 16'h03E8;
	localparam logic [15:0] OUT_SEL_RST     = 16'h0000;
	localparam logic [15:0] DELAY_MAX       = 16'h0BB8;
	localparam logic [15:0] SPEED_MIN       = 16'h001E;
	localparam logic [15:0] SPEED_MAX       = 16'h0BB8;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int unsigned DOUT_N          = 8;

	typedef enum logic [2:0] {
		HBS_ENGAGED   = 3'h0,
		HBS_RELEASING = 3'h1,
		HBS_RUN       = 3'h3,
		HBS_DECEL     = 3'h2,
		HBS_POWEROFF  = 3'h6
	} hbs_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} hbs_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} hbs_axi_rsp_t;
endpackage

//--- design/hbs_sequencer.sv
// holding brake sequencer with AXI4-Lite register slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module hbs_sequencer
	import hbs_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
)(
	input  wire logic                  clk_i,        // 25 MHz clock
	input  wire logic                  reset_i,      // synchronous, active high
	input  wire logic                  clk_en_i,     // freezes all state while low
	input  wire hbs_pkg::hbs_axi_req_t axi_req_i,    // AXI4-Lite master signals
	output      hbs_pkg::hbs_axi_rsp_t axi_rsp_o,    // AXI4-Lite slave signals
	input  wire logic                  servo_enable_in_i, // servo on level
	input  wire logic [15:0]           motor_speed_i,     // |speed| in RPM
	output      logic                  motor_power_o,     // motor current enabled
	output      logic                  cmd_mask_o,        // motion commands ignored
	output      logic                  brake_release_out_o, // 1 = brake released
	output      logic [DOUT_N-1:0]     dout_o             // digital outputs
);
	import hbs_pkg::*;

	typedef struct packed {
		hbs_axi_rsp_t      rsp;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic [15:0]       engage_dly;
		logic [15:0]       release_dly;
		logic [15:0]       speed_thr;
		logic [15:0]       decel_lim;
		logic [15:0]       out_sel;
		hbs_state_t        state;
		logic [$clog2(TICK_CYC+1)-1:0] pre;
		logic [15:0]       ms;
		logic              pwr;
		logic              mask;
		logic              brk;
		logic [DOUT_N-1:0] dout;
	} hbs_regs_t;

	hbs_regs_t r;
	hbs_regs_t next_r;

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [15:0] w_idx;
	logic [15:0] r_idx;
	logic        tick;
	logic        slow;
	assign w_idx = r.aw_addr[17:2];
	assign r_idx = axi_req_i.araddr[17:2];
	assign tick  = (r.pre == '0);
	assign slow  = (motor_speed_i < r.speed_thr);

	always_comb
	begin
		next_r = r;
		// write channel: address and data taken in either order
		if (axi_req_i.awvalid && r.rsp.awready)
		begin
			next_r.aw_got      = 1'b1;
			next_r.aw_addr     = axi_req_i.awaddr;
			next_r.rsp.awready = 1'b0;
		end
		if (axi_req_i.wvalid && r.rsp.wready)
		begin
			next_r.w_got      = 1'b1;
			next_r.w_data     = axi_req_i.wdata;
			next_r.w_strb     = axi_req_i.wstrb;
			next_r.rsp.wready = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.rsp.bvalid)
		begin
			next_r.rsp.bvalid = 1'b1;
			next_r.rsp.bresp  = RESP_OKAY;
			next_r.aw_got     = 1'b0;
			next_r.w_got      = 1'b0;
			if (r.aw_addr[1:0] != 2'h0)
				next_r.rsp.bresp = RESP_SLVERR;
			else if (w_idx == IDX_ENGAGE_DLY)
				next_r.engage_dly = clamp(merge(r.engage_dly, r.w_data, r.w_strb),
					16'h0000, DELAY_MAX);
			else if (w_idx == IDX_RELEASE_DLY)
				next_r.release_dly = clamp(merge(r.release_dly, r.w_data, r.w_strb),
					16'h0000, DELAY_MAX);
			else if (w_idx == IDX_SPEED_THR)
				next_r.speed_thr = clamp(merge(r.speed_thr, r.w_data, r.w_strb),
					SPEED_MIN, SPEED_MAX);
			else if (w_idx == IDX_DECEL_LIM)
				next_r.decel_lim = merge(r.decel_lim, r.w_data, r.w_strb);
			else if (w_idx == IDX_OUT_SEL)
				next_r.out_sel = merge(r.out_sel, r.w_data, r.w_strb);
			else if (w_idx != IDX_STATUS)
				next_r.rsp.bresp = RESP_SLVERR;
		end
		if (r.rsp.bvalid && axi_req_i.bready)
		begin
			next_r.rsp.bvalid  = 1'b0;
			next_r.rsp.awready = 1'b1;
			next_r.rsp.wready  = 1'b1;
		end
		// read channel
		if (axi_req_i.arvalid && r.rsp.arready)
		begin
			next_r.rsp.arready = 1'b0;
			next_r.rsp.rvalid  = 1'b1;
			next_r.rsp.rresp   = RESP_OKAY;
			next_r.rsp.rdata   = 32'h0000_0000;
			if (axi_req_i.araddr[1:0] != 2'h0)
				next_r.rsp.rresp = RESP_SLVERR;
			else if (r_idx == IDX_ENGAGE_DLY)
				next_r.rsp.rdata[15:0] = r.engage_dly;
			else if (r_idx == IDX_RELEASE_DLY)
				next_r.rsp.rdata[15:0] = r.release_dly;
			else if (r_idx == IDX_SPEED_THR)
				next_r.rsp.rdata[15:0] = r.speed_thr;
			else if (r_idx == IDX_DECEL_LIM)
				next_r.rsp.rdata[15:0] = r.decel_lim;
			else if (r_idx == IDX_OUT_SEL)
				next_r.rsp.rdata[15:0] = r.out_sel;
			else if (r_idx == IDX_STATUS)
				next_r.rsp.rdata = {16'h0000, r.ms};
			else
				next_r.rsp.rresp = RESP_SLVERR;
		end
		if (r.rsp.rvalid && axi_req_i.rready)
		begin
			next_r.rsp.rvalid  = 1'b0;
			next_r.rsp.arready = 1'b1;
		end
		// millisecond tick and sequencer
		next_r.pre = tick ? TICK_CYC[$bits(r.pre)-1:0] - 1'b1 : r.pre - 1'b1;
		if (tick && r.ms != 16'hFFFF)
			next_r.ms = r.ms + 16'h0001;
		unique case (r.state)
			HBS_ENGAGED:
			begin
				next_r.pwr  = 1'b0;
				next_r.brk  = 1'b0;
				next_r.mask = 1'b1;
				if (servo_enable_in_i)
				begin
					// release and power-up take effect in the same cycle, far inside the limit
					next_r.state = HBS_RELEASING;
					next_r.pwr   = 1'b1;
					next_r.brk   = 1'b1;
					next_r.ms    = 16'h0000;
					next_r.pre   = TICK_CYC[$bits(r.pre)-1:0] - 1'b1;
				end
			end
			HBS_RELEASING:
			begin
				if (!servo_enable_in_i)
				begin
					next_r.state = HBS_DECEL;
					next_r.ms    = 16'h0000;
				end
				else if (r.ms >= r.release_dly)
				begin
					next_r.state = HBS_RUN;
					next_r.mask  = 1'b0;
				end
			end
			HBS_RUN:
			begin
				if (!servo_enable_in_i)
				begin
					next_r.state = HBS_DECEL;
					next_r.mask  = 1'b1;
					next_r.ms    = 16'h0000;
					next_r.pre   = TICK_CYC[$bits(r.pre)-1:0] - 1'b1;
				end
			end
			HBS_DECEL:
			begin
				next_r.mask = 1'b1;
				if (slow || r.ms >= r.decel_lim)
				begin
					next_r.state = HBS_POWEROFF;
					next_r.pwr   = 1'b0;
					next_r.ms    = 16'h0000;
					next_r.pre   = TICK_CYC[$bits(r.pre)-1:0] - 1'b1;
				end
			end
			HBS_POWEROFF:
			begin
				if (r.ms >= r.engage_dly)
				begin
					next_r.state = HBS_ENGAGED;
					next_r.brk   = 1'b0;
				end
			end
			default:
				next_r.state = HBS_ENGAGED;
		endcase
		for (int i = 0; i < DOUT_N; i++)
			next_r.dout[i] = (r.out_sel[2:0] == i[2:0]) && next_r.brk;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			r             <= '0;
			r.rsp.awready <= 1'b1;
			r.rsp.wready  <= 1'b1;
			r.rsp.arready <= 1'b1;
			r.engage_dly  <= ENGAGE_DLY_RST;
			r.release_dly <= RELEASE_DLY_RST;
			r.speed_thr   <= SPEED_THR_RST;
			r.decel_lim   <= DECEL_LIM_RST;
			r.out_sel     <= OUT_SEL_RST;
			r.state       <= HBS_ENGAGED;
			r.mask        <= 1'b1;
		end
		else if (clk_en_i)
			r <= next_r;
	end

	assign axi_rsp_o           = r.rsp;
	assign motor_power_o       = r.pwr;
	assign cmd_mask_o          = r.mask;
	assign brake_release_out_o = r.brk;
	assign dout_o              = r.dout;
endmodule

//--- tb/hbs_sequencer_sva.sv
// concurrent checks on the brake sequencer ports
`timescale 1ns/1ps
module hbs_sequencer_sva
	import hbs_pkg::*;
(
	input wire logic                  clk_i, reset_i, clk_en_i,
	input wire hbs_pkg::hbs_axi_req_t axi_req_i,
	input wire hbs_pkg::hbs_axi_rsp_t axi_rsp_o,
	input wire logic                  servo_enable_in_i,
	input wire logic [15:0]           motor_speed_i,
	input wire logic                  motor_power_o, cmd_mask_o, brake_release_out_o,
	input wire logic [DOUT_N-1:0]     dout_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_release_fast: assert property (clk_en_i && servo_enable_in_i && !brake_release_out_o
		|=> brake_release_out_o) else $error("late release");
	a_power_released: assert property (motor_power_o |-> brake_release_out_o)
		else $error("powered while braked");
	a_engage_after_off: assert property ($fell(brake_release_out_o)
		|-> !$past(motor_power_o)) else $error("brake before power off");
	a_dout_follows: assert property ((|dout_o) == brake_release_out_o)
		else $error("output mismatch");
	a_mask_disable: assert property (clk_en_i && !servo_enable_in_i |=> cmd_mask_o)
		else $error("mask low when disabled");
	a_mask_unpowered: assert property (!motor_power_o |-> cmd_mask_o)
		else $error("mask low when unpowered");
	a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready
		&& axi_req_i.wvalid && axi_rsp_o.wready |-> ##[1:2] axi_rsp_o.bvalid)
		else $error("no write answer");
	a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready && clk_en_i
		|=> axi_rsp_o.rvalid) else $error("no read answer");
	a_ready_low: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
		else $error("ready during answer");
	c_engage: cover property ($fell(brake_release_out_o));
	c_unmask: cover property ($fell(cmd_mask_o));
	c_write: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
endmodule
bind hbs_sequencer hbs_sequencer_sva u_sva (.*);

//--- tb/hbs_motor_model.sv
// motor with holding brake: the shaft locks as soon as the brake output drops
`timescale 1ns/1ps
module hbs_motor_model
(
	input  wire logic        clk_i,       // clock
	input  wire logic        reset_i,     // sync reset
	input  wire logic        brake_rel_i, // brake output, 1 = released
	input  wire logic [15:0] target_i,    // commanded speed
	input  wire logic        slow_i,      // heavy load that keeps its speed
	output      logic [15:0] speed_o      // shaft speed
);
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !brake_rel_i)
			speed_o <= 16'h0000;
		else if (!slow_i)
			speed_o <= target_i;
	end
endmodule

//--- tb/tb_holding_brake_sequencer.sv
// bench: registers over AXI4-Lite and brake timing against a motor model
`timescale 1ns/1ps
module tb_holding_brake_sequencer;
	import hbs_pkg::*;
	localparam int T = 4;
	logic              clk_i = 0, reset_i = 1, clk_en_i = 1, srv = 0, slow = 0;
	hbs_axi_req_t      rq = '0;
	hbs_axi_rsp_t      rsp;
	logic [15:0]       spd, tgt = 0, ed, rd;
	logic              pwr, mask, rel;
	logic [DOUT_N-1:0] dout;
	logic [31:0]       d;
	logic [1:0]        r;
	logic [2:0]        s;
	int                failures = 0, samples_checked = 0, n;
	hbs_sequencer #(.TICK_CYC(T)) dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.axi_req_i(rq), .axi_rsp_o(rsp), .servo_enable_in_i(srv), .motor_speed_i(spd),
		.motor_power_o(pwr), .cmd_mask_o(mask), .brake_release_out_o(rel), .dout_o(dout));
	hbs_motor_model u_motor (.clk_i(clk_i), .reset_i(reset_i), .brake_rel_i(|dout),
		.target_i(tgt), .slow_i(slow), .speed_o(spd));
	initial
		forever #20 clk_i = ~clk_i;
	task automatic end_sim;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// delays resolve to whole ms, so allow one tick either way
	function automatic logic win(input int c, input int ms);
		return c > (ms - 1) * T && c <= (ms + 1) * T + 3;
	endfunction
	task automatic ax(input logic w, input logic [15:0] i, input logic [15:0] v);
		@(posedge clk_i);
		rq.awaddr <= {i, 2'b00};
		rq.araddr <= {i, 2'b00};
		rq.wdata <= {16'h0000, v};
		rq.wstrb <= 4'hF;
		{rq.awvalid, rq.wvalid, rq.bready} <= {3{w}};
		{rq.arvalid, rq.rready} <= {2{!w}};
		do
		begin
			@(posedge clk_i);
			if (rsp.awready)
				rq.awvalid <= 1'b0;
			if (rsp.wready)
				rq.wvalid <= 1'b0;
			if (rsp.bvalid)
			begin
				rq.bready <= 1'b0;
				r = rsp.bresp;
			end
			if (rsp.arready)
				rq.arvalid <= 1'b0;
			if (rsp.rvalid)
			begin
				rq.rready <= 1'b0;
				d = rsp.rdata;
				r = rsp.rresp;
			end
		end while (rq.awvalid || rq.wvalid || rq.bready || rq.arvalid || rq.rready);
	endtask
	task automatic wt(input int sel, input logic lvl);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while ((sel == 0 ? rel : sel == 1 ? mask : pwr) !== lvl && n < 5000);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_sim;
	end
	initial
	begin
		void'($urandom(52));
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		ax(0, IDX_ENGAGE_DLY, 0);
		chkv(d, 32'h00000064);
		ax(0, IDX_RELEASE_DLY, 0);
		chkv(d, 32'h00000000);
		ax(0, IDX_SPEED_THR, 0);
		chkv(d, 32'h0000001E);
		ax(0, 16'h2400, 0);
		chkv(r, RESP_SLVERR);
		ax(1, 16'h2400, 16'h0001);
		chkv(r, RESP_SLVERR);
		ax(0, IDX_DECEL_LIM, 0);
		chkv(d, 32'h000003E8);
		ax(1, IDX_STATUS, 16'h0001);
		chkv(r, RESP_OKAY);
		ax(0, IDX_STATUS, 0);
		chkv(r, RESP_OKAY);
		ax(1, IDX_ENGAGE_DLY, 16'hFFFF);
		chkv(r, RESP_OKAY);
		ax(0, IDX_ENGAGE_DLY, 0);
		chkv(d, 32'h00000BB8);
		ax(1, IDX_SPEED_THR, 16'h0005);
		ax(0, IDX_SPEED_THR, 0);
		chkv(d, 32'h0000001E);
		s = 3'($urandom % 8);
		ax(1, IDX_SPEED_THR, 16'h0064);
		ax(1, IDX_DECEL_LIM, 16'h0006);
		ax(1, IDX_OUT_SEL, {13'h0000, s});
		ax(0, IDX_OUT_SEL, 0);
		chkv(d, {29'h00000000, s});
		for (int k = 0; k < 2; k++)
		begin
			ed = 16'($urandom % 4);
			rd = k ? 16'($urandom % 4 + 1) : 16'h0000;
			ax(1, IDX_ENGAGE_DLY, ed);
			ax(1, IDX_RELEASE_DLY, rd);
			slow <= 1'b0;
			tgt <= 16'h03E8;
			srv <= 1'b1;
			wt(0, 1'b1);
			chkv(n <= 2, 1);
			chkv(dout, 1 << s);
			wt(1, 1'b0);
			chkv(win(n, rd), 1);
			repeat (8) @(posedge clk_i);
			// disable while frozen: nothing may move until the enable returns
			clk_en_i <= 1'b0;
			srv <= 1'b0;
			repeat (6) @(posedge clk_i);
			chkv({pwr, mask, rel}, 3'h5);
			clk_en_i <= 1'b1;
			tgt <= 16'h0000;
			slow <= !k;
			wt(2, 1'b0);
			chkv(k ? n <= 5 : win(n, 6), 1);
			wt(0, 1'b0);
			chkv(win(n, ed), 1);
			chkv(dout, 0);
		end
		end_sim;
	end
endmodule
